// ### shared/pfs_pkg.sv
// Purpose: constants and types for the protection fault status bank
// Assumes: 8-bit registers on a plain address/strobe port
// Notes:   all offsets, layouts and reset values live here
//
// Functional notes
// - bit 6 marks a cancelled self test
// - bits 5/4 flag temperature/voltage path faults
// - bits 3/2 flag low/high temp comparator faults
// - bit 1 flags high-voltage comparator fault
// - bit 0 flags low-voltage comparator fault
// - cells 1-8 high-voltage at 0x053D, ascending
// - inputs 1-8 high-temperature at 0x0540
// - inputs 1-8 low-temperature at 0x0541
package pfs_pkg;

  // bus widths
  localparam int unsigned ADDR_W   = 16;
  localparam int unsigned DATA_W   = 8;
  // channel counts of the full register layout
  localparam int unsigned CELL_MAX = 16;
  localparam int unsigned GPIO_MAX = 8;
  localparam int unsigned HALF_W   = 8;

  // status bank offsets
  localparam logic [ADDR_W-1:0] OFS_SELFTEST   = 16'h053b;
  localparam logic [ADDR_W-1:0] OFS_CELL_HV_UP = 16'h053c;
  localparam logic [ADDR_W-1:0] OFS_CELL_HV_LO = 16'h053d;
  localparam logic [ADDR_W-1:0] OFS_CELL_LV_UP = 16'h053e;
  localparam logic [ADDR_W-1:0] OFS_CELL_LV_LO = 16'h053f;
  localparam logic [ADDR_W-1:0] OFS_GPIO_HT    = 16'h0540;
  localparam logic [ADDR_W-1:0] OFS_GPIO_LT    = 16'h0541;
  // interrupt registers
  localparam logic [ADDR_W-1:0] OFS_IRQ_STATUS = 16'h0560;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK   = 16'h0561;

  // reset and idle values
  localparam logic [DATA_W-1:0] RESET_VAL = 8'h00;
  localparam logic [DATA_W-1:0] READ_IDLE = 8'h00;
  localparam logic              BIT_CLR   = 1'b0;
  localparam logic              BIT_SET   = 1'b1;

  // self-test result register layout, msb first
  typedef struct packed {
    logic reserved;
    logic selftest_cancelled;
    logic temp_path_selftest_fault;
    logic volt_path_selftest_fault;
    logic low_temp_comparator_selftest_fault;
    logic high_temp_comparator_selftest_fault;
    logic high_volt_comparator_selftest_fault;
    logic low_volt_comparator_selftest_fault;
  } pfs_selftest_t;

  // fault findings handed over by the self-test sequencer
  typedef struct packed {
    logic temp_path_selftest_fault;
    logic volt_path_selftest_fault;
    logic low_temp_comparator_selftest_fault;
    logic high_temp_comparator_selftest_fault;
    logic high_volt_comparator_selftest_fault;
    logic low_volt_comparator_selftest_fault;
  } pfs_faults_t;

  // live comparator outputs, channel 1 in bit 0
  typedef struct packed {
    logic [CELL_MAX-1:0] cell_high_volt_flag;
    logic [CELL_MAX-1:0] cell_low_volt_flag;
    logic [GPIO_MAX-1:0] gpio_high_temp_flag;
    logic [GPIO_MAX-1:0] gpio_low_temp_flag;
  } pfs_cmp_t;

  // interrupt status and mask layout
  typedef struct packed {
    logic [1:0] spare;
    logic       selftest_cancel_ev;
    logic       selftest_fault_ev;
    logic       gpio_low_temp_ev;
    logic       gpio_high_temp_ev;
    logic       cell_low_volt_ev;
    logic       cell_high_volt_ev;
  } pfs_irq_t;

  // self-test tracking states, gray along idle-run-hold
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_RUN  = 2'b01,
    ST_HOLD = 2'b11
  } pfs_state_t;

endpackage

// ### logic/pfs_sync.sv
// Purpose: two-flop synchroniser for asynchronous level inputs
// Assumes: each bit is an independent slow level
// Notes:   first stage feeds only the second stage
`timescale 1ns/1ps
module pfs_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // asynchronous level in, synchronised level out
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_r;  // first stage, read only by sync_o

  // two registers in series, cleared at reset
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_r <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_r <= async_i;
      sync_o <= meta_r;
    end
  end

endmodule

// ### logic/pfs_sticky.sv
// Purpose: sticky event bits cleared by writing a one
// Assumes: set and clear come from the same clock
// Notes:   a set in the clear cycle wins
`timescale 1ns/1ps
module pfs_sticky #(
  parameter int unsigned WIDTH = 8
) (
  // clock and reset
  input  wire logic             ref_clk_i,
  input  wire logic             rst_n_i,
  // event pulses and write-one-to-clear mask
  input  wire logic [WIDTH-1:0] set_i,
  input  wire logic [WIDTH-1:0] clr_i,
  output logic      [WIDTH-1:0] q_o
);

  logic [WIDTH-1:0] q_nxt;  // next sticky state

  // clear first, then set so new events are never lost
  always_comb
  begin
    q_nxt = (q_o & ~clr_i) | set_i;
  end

  // hold the bits
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      q_o <= '0;
    else
      q_o <= q_nxt;
  end

endmodule

// ### logic/pfs_top.sv
// Purpose: read-only protection fault status bank with interrupt
// Assumes: comparator flags are asynchronous levels; the self-test
//          sequencer runs on ref_clk_i and gives one-cycle pulses
// Notes:   read data appear the cycle after the read strobe only
`timescale 1ns/1ps
module pfs_top
  import pfs_pkg::*;
#(
  parameter int unsigned NUM_CELLS = 16,
  parameter int unsigned NUM_GPIO  = 8
) (
  // clock and reset
  input  wire logic                      ref_clk_i,
  input  wire logic                      rst_n_i,
  // comparator outputs, asynchronous
  input  wire pfs_pkg::pfs_cmp_t         cmp_i,
  // self-test sequencer, same clock
  input  wire logic                      selftest_start_i,
  input  wire logic                      selftest_end_i,
  input  wire logic                      selftest_cancel_i,
  input  wire pfs_pkg::pfs_faults_t      selftest_faults_i,
  // register port
  input  wire logic [pfs_pkg::ADDR_W-1:0] addr_i,
  input  wire logic [pfs_pkg::DATA_W-1:0] wr_data_i,
  input  wire logic                      wr_en_i,
  input  wire logic                      rd_en_i,
  output logic      [pfs_pkg::DATA_W-1:0] rd_data_o,
  // interrupt, level
  output logic                           irq_o
);

  import pfs_pkg::*;

  // refuse channel counts outside 9-16 cells or 1-8 inputs, at elaboration
  if (NUM_CELLS < HALF_W + 1 || NUM_CELLS > CELL_MAX)
  begin
    $error("pfs_top: NUM_CELLS out of range");
  end
  if (NUM_GPIO < 1 || NUM_GPIO > GPIO_MAX)
  begin
    $error("pfs_top: NUM_GPIO out of range");
  end

  // masks that force absent channels to read zero
  // the shift is done in 32 bits so a count of 16 cannot overflow,
  // and the cast keeps only the channel bits on purpose
  localparam logic [CELL_MAX-1:0] CELL_MASK =
    CELL_MAX'((32'h0000_0001 << NUM_CELLS) - 32'h0000_0001);
  localparam logic [GPIO_MAX-1:0] GPIO_MASK =
    GPIO_MAX'((32'h0000_0001 << NUM_GPIO) - 32'h0000_0001);

  // the comparator, self-test and mask state below pairs a _nxt value computed this cycle
  // with the registered value held since the last edge
  // synchronised comparator levels
  pfs_cmp_t      cmp_sync;
  // comparator status registers and next values
  pfs_cmp_t      cmp_r;
  pfs_cmp_t      cmp_nxt;
  // self-test tracking
  pfs_state_t    state_r;
  pfs_state_t    state_nxt;
  pfs_selftest_t st_r;
  pfs_selftest_t st_nxt;
  // interrupt handling
  pfs_irq_t      irq_set;     // event pulses this cycle
  pfs_irq_t      irq_clr;     // write-one-to-clear mask
  pfs_irq_t      irq_status;  // sticky status bits
  pfs_irq_t      mask_r;      // interrupt enables
  pfs_irq_t      mask_nxt;
  logic          irq_nxt;
  // register read path
  // rd_mux is the plain choice by address, rd_data_nxt the gated answer
  logic [DATA_W-1:0] rd_data_nxt;
  logic [DATA_W-1:0] rd_mux;

  // comparator levels cross into the clock domain
  // each flag is an independent level, so skew between bits of a byte
  // only delays a bit by one cycle, it never invents one
  pfs_sync #(
    .WIDTH ($bits(pfs_cmp_t))
  ) u_cmp_sync (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .async_i   (cmp_i),
    .sync_o    (cmp_sync)
  );

  // comparator status follows the synchronised levels
  // the flags are live: a comparator that drops its flag clears the bit
  // three edges later, nothing is latched here
  always_comb
  begin
    cmp_nxt = cmp_sync;
    // absent channels always read as no fault
    cmp_nxt.cell_high_volt_flag = cmp_sync.cell_high_volt_flag & CELL_MASK;
    cmp_nxt.cell_low_volt_flag  = cmp_sync.cell_low_volt_flag & CELL_MASK;
    cmp_nxt.gpio_high_temp_flag = cmp_sync.gpio_high_temp_flag & GPIO_MASK;
    cmp_nxt.gpio_low_temp_flag  = cmp_sync.gpio_low_temp_flag & GPIO_MASK;
  end

  // comparator status registers
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      cmp_r <= '0;
    else
      cmp_r <= cmp_nxt;
  end

  // self-test tracking: start clears, end or cancel captures
  // a start inside a run is ignored, as are end and cancel outside one
  // a cancel in the same cycle as an end marks the run cancelled
  // the fault bits are captured for a cancelled run as well
  always_comb
  begin
    state_nxt = state_r;
    st_nxt    = st_r;
    unique case (state_r)
      ST_IDLE,
      ST_HOLD:
      begin
        // a new run wipes the previous result
        // so software never mixes the findings of two runs
        if (selftest_start_i)
        begin
          state_nxt = ST_RUN;
          st_nxt    = RESET_VAL;
        end
      end
      ST_RUN:
      begin
        // cancel takes priority over a normal finish
        // the findings are taken in this very cycle, not before
        if (selftest_cancel_i || selftest_end_i)
        begin
          state_nxt = ST_HOLD;
          st_nxt.temp_path_selftest_fault =
            selftest_faults_i.temp_path_selftest_fault;
          st_nxt.volt_path_selftest_fault =
            selftest_faults_i.volt_path_selftest_fault;
          st_nxt.low_temp_comparator_selftest_fault =
            selftest_faults_i.low_temp_comparator_selftest_fault;
          st_nxt.high_temp_comparator_selftest_fault =
            selftest_faults_i.high_temp_comparator_selftest_fault;
          st_nxt.high_volt_comparator_selftest_fault =
            selftest_faults_i.high_volt_comparator_selftest_fault;
          st_nxt.low_volt_comparator_selftest_fault =
            selftest_faults_i.low_volt_comparator_selftest_fault;
          // set only for a cancelled run, clear on completion
          st_nxt.selftest_cancelled =
            selftest_cancel_i ? BIT_SET : BIT_CLR;
        end
      end
      default:
      begin
        // illegal code recovers to idle
        state_nxt = ST_IDLE;
      end
    endcase
    // reserved bit is held at zero
    // it is forced after the case so no branch can ever set it
    st_nxt.reserved = BIT_CLR;
  end

  // self-test registers
  // state and result share one reset so they can never disagree
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      state_r <= ST_IDLE;
      st_r    <= RESET_VAL;
    end
    else
    begin
      state_r <= state_nxt;
      st_r    <= st_nxt;
    end
  end

  // events: a flag newly raised or a self-test result posted
  // a group event fires once per rising flag, not while a flag stays
  // high, so a stuck comparator raises the interrupt once, not again after a clear
  always_comb
  begin
    irq_set       = RESET_VAL;
    irq_set.cell_high_volt_ev =
      |(cmp_nxt.cell_high_volt_flag & ~cmp_r.cell_high_volt_flag);
    irq_set.cell_low_volt_ev =
      |(cmp_nxt.cell_low_volt_flag & ~cmp_r.cell_low_volt_flag);
    irq_set.gpio_high_temp_ev =
      |(cmp_nxt.gpio_high_temp_flag & ~cmp_r.gpio_high_temp_flag);
    irq_set.gpio_low_temp_ev =
      |(cmp_nxt.gpio_low_temp_flag & ~cmp_r.gpio_low_temp_flag);
    // posted when the run leaves the running state
    if (state_r == ST_RUN && state_nxt == ST_HOLD)
    begin
      irq_set.selftest_fault_ev  = |selftest_faults_i;
      irq_set.selftest_cancel_ev = selftest_cancel_i;
    end
  end

  // software clears a status bit by writing a one to it
  // writes to any other address leave the status untouched
  always_comb
  begin
    irq_clr = RESET_VAL;
    if (wr_en_i && addr_i == OFS_IRQ_STATUS)
      irq_clr = wr_data_i;
  end

  // sticky interrupt status
  // a set wins over a clear in the same cycle, so an event that lands
  // on the clearing write is never lost
  pfs_sticky #(
    .WIDTH ($bits(pfs_irq_t))
  ) u_irq_status (
    .ref_clk_i (ref_clk_i),
    .rst_n_i   (rst_n_i),
    .set_i     (irq_set),
    .clr_i     (irq_clr),
    .q_o       (irq_status)
  );

  // mask register: the only plain read-write register
  // spare bits are forced low so a read shows only real enables
  always_comb
  begin
    mask_nxt = mask_r;
    if (wr_en_i && addr_i == OFS_IRQ_MASK)
      mask_nxt = wr_data_i;
    // spare bits stay zero
    mask_nxt.spare = '0;
    // interrupt level from status gated by mask
    // the registered mask is used, so a new mask reaches irq_o
    // two edges after its write
    irq_nxt = |(irq_status & mask_r);
  end

  // mask and interrupt output registers
  // irq_o is a flop so the pin never glitches while flags settle
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      mask_r <= RESET_VAL;
      irq_o  <= BIT_CLR;
    end
    else
    begin
      mask_r <= mask_nxt;
      irq_o  <= irq_nxt;
    end
  end

  // read decode; the status bank has no write path at all
  // the full address is decoded, so no register shows at an alias
  // the interrupt pair sits well clear of the status bank
  always_comb
  begin
    unique case (addr_i)
      OFS_SELFTEST:
        rd_mux = st_r;
      OFS_CELL_HV_UP:
        rd_mux = cmp_r.cell_high_volt_flag[CELL_MAX-1:HALF_W];
      OFS_CELL_HV_LO:
        rd_mux = cmp_r.cell_high_volt_flag[HALF_W-1:0];
      OFS_CELL_LV_UP:
        rd_mux = cmp_r.cell_low_volt_flag[CELL_MAX-1:HALF_W];
      OFS_CELL_LV_LO:
        rd_mux = cmp_r.cell_low_volt_flag[HALF_W-1:0];
      OFS_GPIO_HT:
        rd_mux = cmp_r.gpio_high_temp_flag;
      OFS_GPIO_LT:
        rd_mux = cmp_r.gpio_low_temp_flag;
      OFS_IRQ_STATUS:
        rd_mux = irq_status;
      OFS_IRQ_MASK:
        rd_mux = mask_r;
      default:
        // unmapped addresses read as zero
        rd_mux = READ_IDLE;
    endcase
  end

  // read data stand only in the cycle after the strobe
  // zero outside the answer cycle keeps a shared read bus quiet
  always_comb
  begin
    rd_data_nxt = rd_en_i ? rd_mux : READ_IDLE;
  end

  // read data register
  // the only driver of rd_data_o, so the port is a pure flop output
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      rd_data_o <= READ_IDLE;
    else
      rd_data_o <= rd_data_nxt;
  end

endmodule

// ### dv/pfs_props.sv
// Purpose: concurrent checks on the status bank register port
// Assumes: default channel counts, a single clock domain
// Notes:   a small tracker mirrors the self-test run state
`timescale 1ns/1ps
module pfs_props
  import pfs_pkg::*;
#(
  parameter int unsigned NUM_CELLS = 16,
  parameter int unsigned NUM_GPIO  = 8
) (
  // clock and reset
  input  wire logic                       ref_clk_i,
  input  wire logic                       rst_n_i,
  // observed inputs
  input  wire pfs_pkg::pfs_cmp_t          cmp_i,
  input  wire logic                       selftest_start_i,
  input  wire logic                       selftest_end_i,
  input  wire logic                       selftest_cancel_i,
  input  wire pfs_pkg::pfs_faults_t       selftest_faults_i,
  input  wire logic [pfs_pkg::ADDR_W-1:0] addr_i,
  input  wire logic                       rd_en_i,
  // observed output
  input  wire logic [pfs_pkg::DATA_W-1:0] rd_data_o
);
  logic run_r;   // a run is in progress
  logic run_nxt; // next run state
  // a run opens on start and closes on end or cancel
  always_comb
  begin
    run_nxt = run_r ? !(selftest_end_i || selftest_cancel_i) : selftest_start_i;
  end
  // register the run state
  always_ff @(posedge ref_clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
      run_r <= 1'b0;
    else
      run_r <= run_nxt;
  end
  default clocking cb @(posedge ref_clk_i);
  endclocking
  default disable iff (!rst_n_i);
  // a run closing, cancelled or not
  sequence s_close(logic c);
    run_r && selftest_cancel_i == c && (c || selftest_end_i);
  endsequence
  // a read strobe at one address
  sequence s_read(logic [15:0] a);
    rd_en_i && addr_i == a;
  endsequence
  // flags held steady past the synchroniser read back as one byte
  property p_flag(logic [15:0] a, logic [7:0] v);
    ($stable(cmp_i)[*5] ##0 s_read(a)) |=> rd_data_o == $past(v);
  endproperty
  a_cancel_flag: assert property (s_close(1'b1) ##1 s_read(OFS_SELFTEST) |=> rd_data_o[6])
    else $error("cancel bit not set");
  a_done_clear: assert property (s_close(1'b0) ##1 s_read(OFS_SELFTEST) |=> !rd_data_o[6])
    else $error("cancel bit set after normal end");
  a_path_bits: assert property (run_r && (selftest_end_i || selftest_cancel_i) ##1
    s_read(OFS_SELFTEST) |=> rd_data_o[5:4] == $past({selftest_faults_i.temp_path_selftest_fault,
    selftest_faults_i.volt_path_selftest_fault}, 2)) else $error("path fault bits wrong");
  a_temp_bits: assert property (run_r && (selftest_end_i || selftest_cancel_i) ##1
    s_read(OFS_SELFTEST) |=> rd_data_o[3:2] == $past({
    selftest_faults_i.low_temp_comparator_selftest_fault,
    selftest_faults_i.high_temp_comparator_selftest_fault}, 2)) else $error("temp bits wrong");
  a_hv_bit: assert property (run_r && (selftest_end_i || selftest_cancel_i) ##1
    s_read(OFS_SELFTEST) |=> rd_data_o[1] ==
    $past(selftest_faults_i.high_volt_comparator_selftest_fault, 2)) else $error("bit 1 wrong");
  a_lv_bit: assert property (run_r && (selftest_end_i || selftest_cancel_i) ##1
    s_read(OFS_SELFTEST) |=> rd_data_o[0] ==
    $past(selftest_faults_i.low_volt_comparator_selftest_fault, 2)) else $error("bit 0 wrong");
  a_rsvd_zero: assert property (s_read(OFS_SELFTEST) |=> !rd_data_o[7])
    else $error("reserved bit set");
  a_read_idle: assert property (!rd_en_i |=> rd_data_o == RESET_VAL)
    else $error("read data without strobe");
  a_hv_lower: assert property (p_flag(OFS_CELL_HV_LO, cmp_i.cell_high_volt_flag[7:0]))
    else $error("high volt cells 1-8 wrong");
  a_hv_upper: assert property (p_flag(OFS_CELL_HV_UP, cmp_i.cell_high_volt_flag[15:8]))
    else $error("high volt cells 9-16 wrong");
  a_ht_map: assert property (p_flag(OFS_GPIO_HT, cmp_i.gpio_high_temp_flag))
    else $error("high temp inputs wrong");
  a_lt_map: assert property (p_flag(OFS_GPIO_LT, cmp_i.gpio_low_temp_flag))
    else $error("low temp inputs wrong");
  a_lv_upper: assert property (p_flag(OFS_CELL_LV_UP, cmp_i.cell_low_volt_flag[15:8]))
    else $error("low volt cells 9-16 wrong");
  a_lv_lower: assert property (p_flag(OFS_CELL_LV_LO, cmp_i.cell_low_volt_flag[7:0]))
    else $error("low volt cells 1-8 wrong");
endmodule

bind pfs_top pfs_props #(.NUM_CELLS(NUM_CELLS), .NUM_GPIO(NUM_GPIO)) u_props (
  .ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .cmp_i(cmp_i),
  .selftest_start_i(selftest_start_i), .selftest_end_i(selftest_end_i),
  .selftest_cancel_i(selftest_cancel_i), .selftest_faults_i(selftest_faults_i),
  .addr_i(addr_i), .rd_en_i(rd_en_i), .rd_data_o(rd_data_o));

// ### dv/protection_fault_status_bank_tb.sv
// Purpose: self-checking bench for the protection fault status bank
// Assumes: default channel counts, read data one cycle after the strobe
// Notes:   expectations come from the driven inputs, never from the outputs
`timescale 1ns/1ps
module protection_fault_status_bank_tb;
  import pfs_pkg::*;
  logic              clk = 1'b0;   // 10 MHz clock
  logic              rst_n = 1'b0; // reset, active low
  pfs_cmp_t          cmp = '0;     // comparator levels
  logic              st_go = 1'b0; // self-test start pulse
  logic              st_end = 1'b0; // self-test end pulse
  logic              st_cnl = 1'b0; // self-test cancel pulse
  pfs_faults_t       st_f = '0;    // self-test findings
  logic [ADDR_W-1:0] addr = '0;    // register address
  logic [DATA_W-1:0] wdata = '0;   // write data
  logic              wr_en = 1'b0; // write strobe
  logic              rd_en = 1'b0; // read strobe
  logic [DATA_W-1:0] rd_data;      // read data
  logic              irq;          // interrupt level
  logic [DATA_W-1:0] res;          // modelled self-test result
  logic [DATA_W-1:0] exp_q [$];    // modelled flag bytes in table order
  int                n_mismatch = 0; // mismatches seen
  int                n_checks = 0;   // comparisons made
  // bank offsets plus one unmapped place
  logic [ADDR_W-1:0] ofs [8] = '{OFS_SELFTEST, OFS_CELL_HV_UP, OFS_CELL_HV_LO, OFS_CELL_LV_UP,
    OFS_CELL_LV_LO, OFS_GPIO_HT, OFS_GPIO_LT, 16'h0542};
  pfs_top u_dut (.ref_clk_i(clk), .rst_n_i(rst_n), .cmp_i(cmp), .selftest_start_i(st_go),
    .selftest_end_i(st_end), .selftest_cancel_i(st_cnl), .selftest_faults_i(st_f),
    .addr_i(addr), .wr_data_i(wdata), .wr_en_i(wr_en), .rd_en_i(rd_en), .rd_data_o(rd_data),
    .irq_o(irq));
  // free-running clock
  initial
  begin
    forever #50 clk = ~clk;
  end
  // byte compare with report
  task automatic chk_byte(input string what, input logic [7:0] e, input logic [7:0] s);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %h seen %h", what, e, s);
    end
  endtask
  // interrupt level compare with report
  task automatic chk_bit(input string what, input logic e, input logic s);
    n_checks++;
    if (s !== e)
    begin
      n_mismatch++;
      $display("[ERR] %s expected %b seen %b", what, e, s);
    end
  endtask
  // one-cycle write, then one idle edge before the next request
  task automatic wr(input logic [15:0] a, input logic [7:0] d);
    wr_en <= 1'b1;
    addr  <= a;
    wdata <= d;
    @(posedge clk);
    wr_en <= 1'b0;
    @(posedge clk);
  endtask
  // one-cycle read, data checked in the following cycle
  task automatic rd(input logic [15:0] a, input logic [7:0] e);
    rd_en <= 1'b1;
    addr  <= a;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk_byte($sformatf("reg %h", a), e, rd_data);
  endtask
  // one self-test run closed by end or cancel
  task automatic selftest(input logic c, input pfs_faults_t f);
    st_go <= 1'b1;
    @(posedge clk);
    st_go <= 1'b0;
    @(posedge clk);
    st_cnl <= c;
    st_end <= !c;
    st_f   <= f;
    @(posedge clk);
    st_cnl <= 1'b0;
    st_end <= 1'b0;
    res = {1'b0, c, f};
  endtask
  // read every flag register against the driven levels
  task automatic flags();
    repeat (5) @(posedge clk);
    exp_q = {cmp.cell_high_volt_flag[15:8], cmp.cell_high_volt_flag[7:0],
      cmp.cell_low_volt_flag[15:8], cmp.cell_low_volt_flag[7:0],
      cmp.gpio_high_temp_flag, cmp.gpio_low_temp_flag};
    for (int i = 1; i < 7; i++)
      rd(ofs[i], exp_q.pop_front());
  endtask
  // verdict and end of run
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  // watchdog against a hang
  initial
  begin
    repeat (5000) @(posedge clk);
    n_mismatch++;
    tally_and_finish();
  end
  // main sequence
  initial
  begin
    void'($urandom(32'hdbcee1a8));
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values, writes ignored, unmapped reads zero
    for (int i = 0; i < 8; i++)
    begin
      rd(ofs[i], 8'h00);
      wr(ofs[i], 8'hff);
      rd(ofs[i], 8'h00);
    end
    // random comparator levels land in the right bits
    for (int n = 0; n < 20; n++)
    begin
      cmp <= 48'({$urandom(), $urandom()});
      flags();
    end
    // each finding alone, by end and by cancel
    for (int k = 0; k < 6; k++)
      for (int c = 0; c < 2; c++)
      begin
        selftest(c[0], pfs_faults_t'(6'(1 << k)));
        rd(OFS_SELFTEST, res);
      end
    // random findings, then a stray cancel outside a run
    selftest(1'b0, pfs_faults_t'(6'($urandom())));
    @(posedge clk);
    st_cnl <= 1'b1;
    @(posedge clk);
    st_cnl <= 1'b0;
    rd(OFS_SELFTEST, res);
    // a start held into the run is ignored; cancel beats end in one cycle
    st_go <= 1'b1;
    @(posedge clk);
    @(posedge clk);
    st_go  <= 1'b0;
    st_cnl <= 1'b1;
    st_end <= 1'b1;
    st_f   <= 6'h15;
    @(posedge clk);
    st_cnl <= 1'b0;
    st_end <= 1'b0;
    rd(OFS_SELFTEST, 8'h55);
    // a new start wipes the result, a plain end keeps bit 6 low
    st_go <= 1'b1;
    @(posedge clk);
    st_go <= 1'b0;
    rd(OFS_SELFTEST, 8'h00);
    st_end <= 1'b1;
    @(posedge clk);
    st_end <= 1'b0;
    rd(OFS_SELFTEST, 8'h15);
    // interrupt: clear, unmask, raise, mask, clear
    cmp <= '0;
    repeat (5) @(posedge clk);
    wr(OFS_IRQ_STATUS, 8'hff);
    wr(OFS_IRQ_MASK, 8'hff);
    rd(OFS_IRQ_MASK, 8'h3f);
    rd(OFS_IRQ_STATUS, 8'h00);
    selftest(1'b1, '0);
    rd(OFS_IRQ_STATUS, 8'h20);
    chk_bit("irq raised", 1'b1, irq);
    wr(OFS_IRQ_MASK, 8'h10);
    repeat (2) @(posedge clk);
    #1 chk_bit("irq masked", 1'b0, irq);
    wr(OFS_IRQ_MASK, 8'h3f);
    wr(OFS_IRQ_STATUS, 8'h20);
    repeat (2) @(posedge clk);
    #1 chk_bit("irq cleared", 1'b0, irq);
    cmp.cell_high_volt_flag[0] <= 1'b1;
    repeat (5) @(posedge clk);
    rd(OFS_IRQ_STATUS, 8'h01);
    chk_bit("irq flag", 1'b1, irq);
    tally_and_finish();
  end
endmodule
